// ==== core/sar_adc_pkg.sv ====
// Contract
// (RULE1) Subsystem runs only while enable bit set
// (RULE2) Channel select picks one of eight inputs
// (RULE3) Gain selectable 0.5/1/2/4, resets to 0.5
// (RULE4) Conversion clock is system clock over divider+1
// (RULE5) Software keeps conversion clock at 7.5 MHz max
// (RULE6) Start mode picks one of five triggers
// (RULE7) External start acts on detected rising edge
// (RULE8) Own start pin wins over shared pin
// (RULE9) Shared pin alone may start both converters
// (RULE10) Other converter busy write starts both
// (RULE11) Busy reads one throughout each conversion
// (RULE12) Busy falling sets the done flag
// (RULE13) Finished result lands in result register
// (RULE14) Software clears flag, starts, polls, reads
// (RULE15) Normal mode tracks except while converting
// (RULE16) Low-power mode tracks three conversion clocks first
// (RULE17) Low-power pin mode tracks while pin low
// (RULE18) Tracking off during chip standby or sleep
// (RULE19) Software waits 0.8 us after channel change
// (RULE20) Analog pins skipped by the digital crossbar
// (RULE21) Mode 000 busy write, 001 timer 3
// (RULE22) Busy write starts only in mode 000
// (RULE23) Done flag stays until software writes zero
// (RULE24) Gain codes 00/01/10/11 for 0.5/1/2/4
// (RULE25) Conversion lasts fixed clocks, then result latched
// (RULE26) Triggers during tracking or conversion are ignored
package sar_adc_pkg;

   localparam logic [7:0] OFS_CFG    = 8'h00;
   localparam logic [7:0] OFS_CTL    = 8'h04;
   localparam logic [7:0] OFS_CHAN   = 8'h08;
   localparam logic [7:0] OFS_RESULT = 8'h0c;
   localparam logic [7:0] OFS_PIM    = 8'h10;

   localparam logic [7:0] CFG_RESET = 8'hf8;
   localparam logic [7:0] PIM_RESET = 8'hff;

   localparam int CFG_DIV_LSB  = 3;
   localparam int CTL_EN_BIT   = 7;
   localparam int CTL_TM_BIT   = 6;
   localparam int CTL_FLAG_BIT = 5;
   localparam int CTL_BUSY_BIT = 4;
   localparam int CTL_MODE_LSB = 1;
   localparam int CHAN_OK_BIT  = 7;

   localparam logic [1:0] GAIN_HALF = 2'h0;
   localparam logic [1:0] GAIN_ONE  = 2'h1;
   localparam logic [1:0] GAIN_TWO  = 2'h2;
   localparam logic [1:0] GAIN_FOUR = 2'h3;

   localparam logic [2:0] SM_SW    = 3'h0;
   localparam logic [2:0] SM_T3    = 3'h1;
   localparam logic [2:0] SM_EXT   = 3'h2;
   localparam logic [2:0] SM_T2    = 3'h3;
   localparam logic [2:0] SM_OTHER = 3'h4;

   localparam int SAR_BITS      = 8;
   localparam int LP_TRACK_CLKS = 3;
   localparam int CLK_PERIOD_PS = 25000;
   localparam int SETTLE_PS     = 800000;
   localparam int SETTLE_CYC    = (SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int MAX_CONV_KHZ  = 7500;

   typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} seq_state_e;

endpackage : sar_adc_pkg

// ==== core/sar_tick_if.sv ====
`timescale 1ns/1ps
interface sar_tick_if;
   logic [4:0] divider;
   logic       run;
   logic       tick;

   modport ctrl (output divider, output run, input tick);
   modport gen  (input divider, input run, output tick);
endinterface : sar_tick_if

// ==== core/sar_clk_div.sv ====
`timescale 1ns/1ps
module sar_clk_div
   import sar_adc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   sar_tick_if.gen  tk
);
   typedef struct packed {
      logic [4:0] cnt;
   } div_state_s;

   div_state_s q;
   div_state_s d;

   // (RULE4) divide by field plus one
   assign tk.tick = tk.run && (q.cnt == tk.divider);

   always_comb
   begin
      d = q;
      if (!tk.run || tk.tick)
         d.cnt = 5'h0;
      else
         d.cnt = q.cnt + 5'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   tick_spacing_a: assert property ((tk.tick && tk.divider != 5'h0 && tk.run) |=> !tk.tick) // RULE4
      else $error("conversion clock ticks too close together");
   tick_div_one_a: assert property ((tk.run && tk.divider == 5'h0) |-> tk.tick) // RULE4
      else $error("divide by one must tick every cycle");

endmodule : sar_clk_div

// ==== core/sar_adc_ctrl.sv ====
`timescale 1ns/1ps
module sar_adc_ctrl
   import sar_adc_pkg::*;
#(
   parameter int CONV_CLKS = 10
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer3_ovf,
   input  wire logic        timer2_ovf,
   input  wire logic        other_start_sw,
   input  wire logic        ext_start_own,
   input  wire logic        ext_start_shared,
   input  wire logic        own_pin_enabled,
   input  wire logic        shared_pin_enabled,
   input  wire logic        chip_standby,
   input  wire logic        comp_high,
   output logic             analog_enable,
   output logic             track_enable,
   output logic             hold_convert,
   output logic [2:0]       mux_select,
   output logic [1:0]       amp_gain_field,
   output logic [7:0]       dac_code,
   output logic [7:0]       analog_skip,
   output logic             conv_done_pulse
);
   typedef struct packed {
      logic [4:0]  sar_clock_divider;
      logic [1:0]  amp_gain;
      logic        conv_enable;
      logic        track_mode_select;
      logic        conv_done_flag;
      logic [2:0]  start_mode_select;
      logic [2:0]  channel;
      logic [5:0]  settle;
      logic [7:0]  port_mode;
      logic [7:0]  result;
      logic [7:0]  code;
      seq_state_e  state;
      logic [4:0]  cnt;
      logic [2:0]  own_sync;
      logic [2:0]  shared_sync;
      logic        own_level;
      logic        shared_level;
      logic        ext_prev;
      logic        done_p;
      logic [31:0] rdata;
      logic        err;
   } ctrl_state_s;

   ctrl_state_s q;
   ctrl_state_s d;

   sar_tick_if tk ();

   sar_clk_div u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .tk      (tk)
   );

   logic       wr_access;
   logic       wr_ctl;
   logic       sw_start;
   logic       ext_level;
   logic       ext_rise;
   logic       trig;
   logic       conv_last;
   logic       lp_pin_mode;
   logic [7:0] code_nx;
   logic [2:0] bit_idx;

   assign wr_access = psel && penable && pwrite;
   assign wr_ctl    = wr_access && (paddr == OFS_CTL);

   // (RULE22) busy write counts only in mode 000
   assign sw_start = wr_ctl && pwdata[CTL_BUSY_BIT]
                     && (pwdata[CTL_MODE_LSB +: 3] == SM_SW);

   // (RULE8) own pin first, shared pin only as fallback
   assign ext_level = own_pin_enabled ? q.own_level : (shared_pin_enabled && q.shared_level);
   // (RULE7) rising edge of the filtered pin
   assign ext_rise  = ext_level && !q.ext_prev;

   assign lp_pin_mode = q.track_mode_select && (q.start_mode_select == SM_EXT);
   assign conv_last   = tk.tick && (q.cnt == 5'(CONV_CLKS - 1));
   assign bit_idx     = 3'(SAR_BITS - 1) - q.cnt[2:0];

   assign tk.divider = q.sar_clock_divider;
   assign tk.run     = (q.state != ST_IDLE);

   // (RULE6) one of five trigger sources
   always_comb
   begin
      case (q.start_mode_select)
         // (RULE21) software and timer 3 modes
         SM_SW:    trig = sw_start;
         SM_T3:    trig = timer3_ovf;
         // (RULE9) shared pin may start both converters
         SM_EXT:   trig = ext_rise;
         SM_T2:    trig = timer2_ovf;
         // (RULE10) other converter's software start
         SM_OTHER: trig = other_start_sw;
         default:  trig = 1'b0;
      endcase
   end

   // Successive approximation: keep or drop the trial bit, set the next one
   always_comb
   begin
      code_nx = q.code;
      if (q.cnt < 5'(SAR_BITS))
      begin
         if (!comp_high)
            code_nx[bit_idx] = 1'b0;
         if (bit_idx != 3'h0)
            code_nx[bit_idx - 3'h1] = 1'b1;
      end
   end

   always_comb
   begin
      d        = q;
      d.done_p = 1'b0;

      // Pin filter: only the second and third stages are compared
      d.own_sync    = {q.own_sync[1:0], ext_start_own};
      d.shared_sync = {q.shared_sync[1:0], ext_start_shared};
      if (q.own_sync[1] == q.own_sync[2])
         d.own_level = q.own_sync[2];
      if (q.shared_sync[1] == q.shared_sync[2])
         d.shared_level = q.shared_sync[2];
      d.ext_prev = ext_level;

      // (RULE19) settle timer restarts on every channel write
      if (q.settle != 6'(SETTLE_CYC))
         d.settle = q.settle + 6'h1;

      if (wr_access)
      begin
         case (paddr)
            OFS_CFG:
            begin
               // (RULE24) two-bit gain code stored as written
               d.sar_clock_divider = pwdata[CFG_DIV_LSB +: 5];
               d.amp_gain          = pwdata[1:0];
            end
            OFS_CTL:
            begin
               d.conv_enable       = pwdata[CTL_EN_BIT];
               d.track_mode_select = pwdata[CTL_TM_BIT];
               d.start_mode_select = pwdata[CTL_MODE_LSB +: 3];
               // (RULE23) only a written zero clears the flag
               if (!pwdata[CTL_FLAG_BIT])
                  d.conv_done_flag = 1'b0;
            end
            OFS_CHAN:
            begin
               // (RULE2) one of eight inputs
               d.channel = pwdata[2:0];
               d.settle  = 6'h0;
            end
            OFS_PIM:
               d.port_mode = pwdata[7:0];
            default:
               d.port_mode = q.port_mode;
         endcase
      end

      // Sequencer; triggers outside idle fall through untouched
      case (q.state)
         ST_IDLE:
         begin
            // (RULE26) triggers only honoured while idle
            if (trig && q.conv_enable)
            begin
               d.cnt = 5'h0;
               // (RULE17) pin edge in low-power mode converts at once
               if (q.track_mode_select && !lp_pin_mode)
                  d.state = ST_TRACK;
               else
               begin
                  d.state = ST_CONV;
                  d.code  = 8'h80;
               end
            end
         end
         ST_TRACK:
         begin
            // (RULE16) three conversion clocks of tracking
            if (tk.tick)
            begin
               d.cnt = q.cnt + 5'h1;
               if (q.cnt == 5'(LP_TRACK_CLKS - 1))
               begin
                  d.state = ST_CONV;
                  d.cnt   = 5'h0;
                  d.code  = 8'h80;
               end
            end
         end
         ST_CONV:
         begin
            if (tk.tick)
            begin
               d.code = code_nx;
               d.cnt  = q.cnt + 5'h1;
            end
            // (RULE25) fixed length, then latch
            if (conv_last)
            begin
               d.state = ST_IDLE;
               // (RULE13) result captured at busy fall
               d.result = code_nx;
               // (RULE12) busy fall sets the flag, set beats clear
               d.conv_done_flag = 1'b1;
               d.done_p         = 1'b1;
            end
         end
         default:
            d.state = ST_IDLE;
      endcase

      // (RULE1) disabled means shutdown; an open conversion is dropped
      if (!q.conv_enable)
         d.state = ST_IDLE;

      // Read data is latched in the setup cycle, answered in access
      if (psel && !penable)
      begin
         d.rdata = 32'h0000_0000;
         d.err   = 1'b0;
         case (paddr)
            OFS_CFG:    d.rdata[7:0] = {q.sar_clock_divider, 1'b0, q.amp_gain};
            // (RULE11) busy reads one while tracking or converting
            OFS_CTL:    d.rdata[7:0] = {q.conv_enable, q.track_mode_select,
                                        q.conv_done_flag, q.state != ST_IDLE,
                                        q.start_mode_select, 1'b0};
            OFS_CHAN:   d.rdata[7:0] = {q.settle == 6'(SETTLE_CYC), 4'h0, q.channel};
            OFS_RESULT: d.rdata[7:0] = q.result;
            OFS_PIM:    d.rdata[7:0] = q.port_mode;
            default:    d.err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
         // (RULE3) gain starts at one half
         q.sar_clock_divider <= CFG_RESET[7:3];
         q.amp_gain          <= GAIN_HALF;
         q.port_mode         <= PIM_RESET;
         q.state             <= ST_IDLE;
      end
      else
         q <= d;
   end

   assign prdata  = q.rdata;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && q.err;

   assign analog_enable   = q.conv_enable;
   assign hold_convert    = (q.state == ST_CONV);
   assign mux_select      = q.channel;
   assign amp_gain_field  = q.amp_gain;
   assign dac_code        = q.code;
   assign conv_done_pulse = q.done_p;
   // (RULE20) pins with a cleared input-mode bit are analog
   assign analog_skip = ~q.port_mode;

   // (RULE15) track unless converting; low-power modes narrow it
   // (RULE18) standby shuts tracking off
   always_comb
   begin
      if (!q.conv_enable || chip_standby)
         track_enable = 1'b0;
      else if (!q.track_mode_select)
         track_enable = (q.state != ST_CONV);
      else if (lp_pin_mode)
         track_enable = (q.state == ST_IDLE) && !ext_level;
      else
         track_enable = (q.state == ST_TRACK);
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   shutdown_idle_a: assert property (!q.conv_enable |=> q.state == ST_IDLE) // RULE1
      else $error("sequencer active while disabled");
   sw_start_go_a: assert property ((sw_start && q.start_mode_select == SM_SW && q.conv_enable
      && q.state == ST_IDLE) |=> q.state != ST_IDLE) // RULE22
      else $error("busy write in mode 000 did not start");
   busy_noeffect_a: assert property ((q.state == ST_IDLE && q.start_mode_select == SM_T3
      && !timer3_ovf) |=> q.state == ST_IDLE) // RULE22
      else $error("conversion started without its trigger");
   done_on_fall_a: assert property ((conv_last && q.state == ST_CONV && q.conv_enable)
      |=> q.conv_done_flag && q.done_p && q.state == ST_IDLE) // RULE12
      else $error("done flag not set at busy fall");
   flag_sticky_a: assert property ((q.conv_done_flag && !(wr_ctl && !pwdata[CTL_FLAG_BIT]))
      |=> q.conv_done_flag) // RULE23
      else $error("done flag cleared by hardware");
   lp_track_end_a: assert property ((q.state == ST_TRACK && tk.tick && q.conv_enable
      && q.cnt == 5'(LP_TRACK_CLKS - 1)) |=> q.state == ST_CONV && q.cnt == 5'h0) // RULE16
      else $error("low-power tracking length wrong");
   track_early_a: assert property ((q.state == ST_TRACK && q.conv_enable
      && q.cnt < 5'(LP_TRACK_CLKS - 1)) |=> q.state == ST_TRACK) // RULE16
      else $error("tracking ended early");
   conv_ignore_a: assert property ((q.state == ST_CONV && q.conv_enable && !conv_last)
      |=> q.state == ST_CONV && q.cnt == $past(q.cnt) + 5'($past(tk.tick))) // RULE26
      else $error("trigger disturbed a running conversion");
   result_latch_a: assert property ((q.state == ST_CONV && conv_last && q.conv_enable)
      |=> q.result == $past(code_nx)) // RULE13
      else $error("result not latched at end of conversion");
   pin_track_a: assert property ((lp_pin_mode && q.conv_enable && !chip_standby
      && q.state == ST_IDLE) |-> track_enable == !ext_level) // RULE17
      else $error("pin mode tracking does not follow the pin");
   normal_track_a: assert property ((!q.track_mode_select && q.conv_enable && !chip_standby)
      |-> track_enable == (q.state != ST_CONV)) // RULE15
      else $error("normal tracking wrong");
   standby_track_a: assert property (chip_standby |-> !track_enable) // RULE18
      else $error("tracking during standby");

endmodule : sar_adc_ctrl

// ==== bench/tb_sar_adc_ctrl.sv ====
`timescale 1ns/1ps
module tb_sar_adc_ctrl
   import sar_adc_pkg::*;
();
   localparam int CONV = 10;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        timer3_ovf;
   logic        timer2_ovf;
   logic        other_start_sw;
   logic        ext_start_own;
   logic        ext_start_shared;
   logic        own_pin_enabled;
   logic        shared_pin_enabled;
   logic        chip_standby;
   logic        comp_high;
   logic        analog_enable;
   logic        track_enable;
   logic        hold_convert;
   logic [2:0]  mux_select;
   logic [1:0]  amp_gain_field;
   logic [7:0]  dac_code;
   logic [7:0]  analog_skip;
   logic        conv_done_pulse;
   logic [7:0]  target;
   logic [31:0] rdat;
   logic        rerr;
   int          fail_count;
   int          cmp_count;
   int          done_cnt;
   int          conv_cyc;
   int          d0;
   int          c0;
   int          n;
   logic [2:0]  modes [4];

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end

   sar_adc_ctrl #(.CONV_CLKS(CONV)) u_sar_adc_ctrl (
      .pclk               (pclk),
      .presetn            (presetn),
      .psel               (psel),
      .penable            (penable),
      .pwrite             (pwrite),
      .paddr              (paddr),
      .pwdata             (pwdata),
      .prdata             (prdata),
      .pready             (pready),
      .pslverr            (pslverr),
      .timer3_ovf         (timer3_ovf),
      .timer2_ovf         (timer2_ovf),
      .other_start_sw     (other_start_sw),
      .ext_start_own      (ext_start_own),
      .ext_start_shared   (ext_start_shared),
      .own_pin_enabled    (own_pin_enabled),
      .shared_pin_enabled (shared_pin_enabled),
      .chip_standby       (chip_standby),
      .comp_high          (comp_high),
      .analog_enable      (analog_enable),
      .track_enable       (track_enable),
      .hold_convert       (hold_convert),
      .mux_select         (mux_select),
      .amp_gain_field     (amp_gain_field),
      .dac_code           (dac_code),
      .analog_skip        (analog_skip),
      .conv_done_pulse    (conv_done_pulse)
   );

   // Ideal comparator, so the search must land on target
   assign comp_high = ((dac_code <= target) === 1'b1);

   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Sampled mid-cycle to stay clear of edge races
   always @(negedge pclk)
   begin
      if (hold_convert === 1'b1) conv_cyc++;
      if (conv_done_pulse === 1'b1) done_cnt++;
   end

   task automatic close_out;
      if (fail_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rdat, e)
   endtask : rd_chk

   function automatic logic [31:0] ctl(input logic en, input logic tm, input logic bz,
                                       input logic [2:0] m);
      ctl = 32'h0000_0000;
      ctl[CTL_EN_BIT] = en;
      ctl[CTL_TM_BIT] = tm;
      ctl[CTL_BUSY_BIT] = bz;
      ctl[CTL_MODE_LSB +: 3] = m;
   endfunction : ctl

   task automatic pin(input logic own);
      @(posedge pclk);
      if (own) ext_start_own <= 1'b1;
      else ext_start_shared <= 1'b1;
      repeat (8) @(posedge pclk);
      ext_start_own    <= 1'b0;
      ext_start_shared <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask : pin

   task automatic fire(input logic [2:0] m);
      @(posedge pclk);
      case (m)
         SM_T3:    timer3_ovf <= 1'b1;
         SM_T2:    timer2_ovf <= 1'b1;
         SM_OTHER: other_start_sw <= 1'b1;
         default:  ;
      endcase
      @(posedge pclk);
      timer3_ovf     <= 1'b0;
      timer2_ovf     <= 1'b0;
      other_start_sw <= 1'b0;
      if (m == SM_EXT) pin(1'b1);
   endtask : fire

   task automatic wait_done;
      int k;
      k = 0;
      while (done_cnt == d0 && k < 600)
      begin
         @(posedge pclk);
         k++;
      end
      if (done_cnt == d0)
         fail_count++;
   endtask : wait_done

   initial
   begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      close_out();
   end

   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, timer3_ovf, timer2_ovf, other_start_sw} = '0;
      {ext_start_own, ext_start_shared, own_pin_enabled, shared_pin_enabled} = '0;
      chip_standby = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      target = 8'h5a;
      modes = '{SM_T3, SM_T2, SM_OTHER, SM_EXT};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(OFS_CFG, {24'h00_0000, CFG_RESET});
      `CHK(amp_gain_field, GAIN_HALF)
      rd_chk(OFS_CTL, 32'h0000_0000);
      rd_chk(OFS_PIM, {24'h00_0000, PIM_RESET});
      `CHK(analog_skip, 8'h00)
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK(rerr, 1'b1)
      for (int g = 0; g < 4; g++)
      begin
         apb(1'b1, OFS_CFG, 32'h0000_0028 + 32'(g));
         @(posedge pclk);
         `CHK(amp_gain_field, 2'(g))
      end
      for (int c = 0; c < 8; c++)
      begin
         apb(1'b1, OFS_CHAN, 32'(c));
         @(posedge pclk);
         `CHK(mux_select, 3'(c))
      end
      // Settled bit reads zero after a channel write, one after SETTLE_CYC cycles
      rd_chk(OFS_CHAN, 32'h0000_0007);
      repeat (SETTLE_CYC) @(posedge pclk);
      rd_chk(OFS_CHAN, 32'h0000_0087);
      apb(1'b1, OFS_PIM, 32'h0000_000f);
      @(posedge pclk);
      `CHK(analog_skip, 8'hf0)
      d0 = done_cnt;
      apb(1'b1, OFS_CTL, ctl(1'b0, 1'b0, 1'b1, SM_SW));
      repeat (60) @(posedge pclk);
      `CHK(done_cnt, d0)
      `CHK({analog_enable, track_enable}, 2'b00)
      apb(1'b1, OFS_CTL, ctl(1'b1, 1'b0, 1'b0, SM_SW));
      @(posedge pclk);
      `CHK({analog_enable, track_enable}, 2'b11)
      chip_standby <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK(track_enable, 1'b0)
      chip_standby <= 1'b0;
      apb(1'b1, OFS_CFG, 32'h0000_0028);
      d0 = done_cnt;
      c0 = conv_cyc;
      apb(1'b1, OFS_CTL, ctl(1'b1, 1'b0, 1'b1, SM_SW));
      rd_chk(OFS_CTL, ctl(1'b1, 1'b0, 1'b1, SM_SW));
      `CHK(track_enable, 1'b0)
      wait_done();
      `CHK(conv_cyc - c0, CONV * 6)
      rd_chk(OFS_RESULT, 32'h0000_005a);
      rd_chk(OFS_CTL, 32'h0000_00a0);
      apb(1'b1, OFS_CTL, 32'h0000_00a0);
      repeat (40) @(posedge pclk);
      rd_chk(OFS_CTL, 32'h0000_00a0);
      apb(1'b1, OFS_CTL, 32'h0000_0080);
      rd_chk(OFS_CTL, 32'h0000_0080);
      // Unused mode code 101 must never start
      d0 = done_cnt;
      apb(1'b1, OFS_CTL, ctl(1'b1, 1'b0, 1'b1, 3'h5));
      fire(SM_T3);
      repeat (20) @(posedge pclk);
      `CHK(done_cnt, d0)
      // Each hardware source, with a repeat mid-conversion that must be dropped
      apb(1'b1, OFS_CFG, 32'h0000_0038);
      own_pin_enabled <= 1'b1;
      target <= 8'hc3;
      for (int i = 0; i < 4; i++)
      begin
         d0 = done_cnt;
         apb(1'b1, OFS_CTL, ctl(1'b1, 1'b0, 1'b1, modes[i]));
         repeat (60) @(posedge pclk);
         `CHK(done_cnt, d0)
         c0 = conv_cyc;
         fire(modes[i]);
         fire(modes[i]);
         wait_done();
         repeat (80) @(posedge pclk);
         `CHK(done_cnt, d0 + 1)
         `CHK(conv_cyc - c0, CONV * 8)
         rd_chk(OFS_RESULT, 32'h0000_00c3);
      end
      // own pin wins, shared pin alone
      shared_pin_enabled <= 1'b1;
      d0 = done_cnt;
      pin(1'b0);
      repeat (60) @(posedge pclk);
      `CHK(done_cnt, d0)
      own_pin_enabled <= 1'b0;
      pin(1'b0);
      wait_done();
      `CHK(done_cnt, d0 + 1)
      // three tracking ticks first
      // Mode must already hold 000 when busy is written
      apb(1'b1, OFS_CTL, ctl(1'b1, 1'b1, 1'b0, SM_SW));
      d0 = done_cnt;
      apb(1'b1, OFS_CTL, ctl(1'b1, 1'b1, 1'b1, SM_SW));
      @(negedge pclk);
      `CHK({track_enable, hold_convert}, 2'b10)
      n = 0;
      while (hold_convert !== 1'b1 && n < 100)
      begin
         @(posedge pclk);
         n++;
      end
      `CHK((n >= 24 && n <= 26), 1'b1)
      wait_done();
      d0 = done_cnt;
      own_pin_enabled <= 1'b1;
      apb(1'b1, OFS_CTL, ctl(1'b1, 1'b1, 1'b0, SM_EXT));
      repeat (10) @(posedge pclk);
      `CHK(track_enable, 1'b1)
      ext_start_own <= 1'b1;
      n = 0;
      while (hold_convert !== 1'b1 && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
      `CHK((n <= 10), 1'b1)
      ext_start_own <= 1'b0;
      wait_done();
      `CHK(done_cnt, d0 + 1)
      close_out();
   end
endmodule : tb_sar_adc_ctrl
